// ---- design/dma_pkg.sv ----
// Constants, field layouts and encodings for the four-channel transfer controller
// Function
// - Timer and external interrupt events are valid channel request sources.
// - A channel moves data one way only, peripheral to memory or reverse.
// - Among pending channels one wins by channel number; the rest stay pending.
// - Each channel moves a block, then signals the CPU the block is ready.
// - Optionally signal the CPU at half block as well as at full block.
// - Memory address either post-increments per element or stays fixed.
// - Peripheral indirect mode takes the memory address from the peripheral.
// - Each element is a byte or a 16-bit word.
// - Transfers start by software force or by peripheral request, per setting.
// - One-shot stops after one block; auto-repeat restarts the block.
// - Ping-pong alternates between two memory start addresses after each block.
// - Each channel picks its request source with an 8-bit select field.
// - Select code 0 routes external interrupt zero, with no peripheral address.
// - Code 1 selects capture unit one, reading its buffer at 0x0144.
// - Code 2 selects compare unit one, writing 0x0906 or 0x0904.
// - Code 0x0D selects converter done, reading result buffer at 0x0300.
// - Code 0x22 selects CAN receive ready, reading port 0x0440.
// - Code 0x46 selects CAN transmit request, writing port 0x0442.
package dma_pkg;

  // Register map, byte addresses
  localparam logic [7:0] CH_STRIDE   = 8'h20;
  localparam logic [4:0] R_CTRL      = 5'h00;
  localparam logic [4:0] R_REQ       = 5'h04;
  localparam logic [4:0] R_STA       = 5'h08;
  localparam logic [4:0] R_STB       = 5'h0C;
  localparam logic [4:0] R_PAD       = 5'h10;
  localparam logic [4:0] R_LEN       = 5'h14;
  localparam logic [4:0] R_CUR       = 5'h18;
  localparam logic [4:0] R_PROG      = 5'h1C;
  localparam logic [7:0] R_STATUS    = 8'h80;
  localparam logic [7:0] R_BUSY      = 8'h84;

  // Control field positions
  localparam int C_EN    = 0;
  localparam int C_BYTE  = 1;
  localparam int C_DIR   = 2;
  localparam int C_HALF  = 3;
  localparam int C_AM    = 4;
  localparam int C_MODE  = 6;
  localparam int C_AUTO  = 8;
  localparam int C_W     = 9;
  localparam int Q_FORCE = 31;
  localparam int ST_HALF = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {AM_POSTINC = 2'b00, AM_FIXED = 2'b01, AM_PERIPH = 2'b10} amode_e;
  typedef enum logic [1:0] {MD_ONESHOT = 2'b00, MD_REPEAT = 2'b01, MD_PINGPONG = 2'b10} mode_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WR = 2'b10} state_e;

  // Request source codes and their peripheral data ports
  localparam logic [7:0]  SRC_EXT_INT_ZERO = 8'h00;
  localparam logic [7:0]  SRC_CAPTURE1   = 8'h01;
  localparam logic [7:0]  SRC_COMPARE1   = 8'h02;
  localparam logic [7:0]  SRC_CONV_DONE  = 8'h0D;
  localparam logic [7:0]  SRC_CAN_RX     = 8'h22;
  localparam logic [7:0]  SRC_CAN_TX     = 8'h46;
  localparam logic [15:0] CAPTURE_ONE_BUFFER    = 16'h0144;
  localparam logic [15:0] COMPARE_ONE_PRIMARY   = 16'h0906;
  localparam logic [15:0] COMPARE_ONE_SECONDARY = 16'h0904;
  localparam logic [15:0] CONVERTER_RESULT_ZERO = 16'h0300;
  localparam logic [15:0] CAN_RECEIVE_PORT      = 16'h0440;
  localparam logic [15:0] CAN_TRANSMIT_PORT     = 16'h0442;
  localparam logic [15:0] PAD_NONE              = 16'h0000;

endpackage

// ---- design/dma_controller.sv ----
// Four-channel memory/peripheral transfer engine with AXI4-Lite registers
`timescale 1ns/1ns
module dma_controller
  import dma_pkg::*;
#(
  parameter int NCH   = 4,
  parameter int SRC_W = 256
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Peripheral request events and indirect address
  input  wire logic [SRC_W-1:0]  irq_events,
  input  wire logic [15:0]       periph_ind_addr,
  // Data bus master
  output logic                   dbus_req,
  output logic                   dbus_we,
  output logic                   dbus_byte,
  output logic [15:0]            dbus_addr,
  output logic [15:0]            dbus_wdata,
  input  wire logic              dbus_ack,
  input  wire logic [15:0]       dbus_rdata,
  // Block events to the CPU
  output logic [NCH-1:0]         half_irq,
  output logic [NCH-1:0]         full_irq
);

  if (NCH < 2 || NCH > 4) begin : g_bad_nch
    $error("NCH must be 2 to 4");
  end
  if (SRC_W < 71 || SRC_W > 256) begin : g_bad_src
    $error("SRC_W must be 71 to 256");
  end

  logic [C_W-1:0] ctrl_q [NCH];
  logic [7:0]     sel_q  [NCH];
  logic [15:0]    sta_q  [NCH];
  logic [15:0]    stb_q  [NCH];
  logic [15:0]    pad_q  [NCH];
  logic [15:0]    len_q  [NCH];
  logic [15:0]    cur_q  [NCH];
  logic [15:0]    cnt_q  [NCH];
  logic [NCH-1:0] pp_q;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] full_st_q;
  logic [NCH-1:0] half_st_q;
  logic [SRC_W-1:0] ev_prev_q;

  state_e         state_q;
  logic [1:0]     ch_q;

  logic           aw_full_q;
  logic           w_full_q;
  logic [7:0]     aw_q;
  logic [31:0]    w_q;
  logic [3:0]     ws_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Lowest numbered pending channel wins
  function automatic logic [1:0] pick(input logic [NCH-1:0] p);
    logic [1:0] r;
    r = 2'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // Default peripheral data port for a request source
  function automatic logic [15:0] default_pad(input logic [7:0] s);
    logic [15:0] r;
    unique case (s)
      SRC_CAPTURE1:  r = CAPTURE_ONE_BUFFER;
      SRC_COMPARE1:  r = COMPARE_ONE_PRIMARY;
      SRC_CONV_DONE: r = CONVERTER_RESULT_ZERO;
      SRC_CAN_RX:    r = CAN_RECEIVE_PORT;
      SRC_CAN_TX:    r = CAN_TRANSMIT_PORT;
      default:       r = PAD_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] eff_len(input logic [15:0] l);
    return (l == 16'h0000) ? 16'h0001 : l;
  endfunction

  // Register bus handshake
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic [1:0] wr_ch;
  logic [4:0] wr_reg;

  assign awready = ~aw_full_q;
  assign wready  = ~w_full_q;
  assign arready = ~rvalid;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid;
  assign rd_fire = arvalid & arready;
  assign wr_ch   = aw_q[6:5];
  assign wr_reg  = aw_q[4:0];
  assign wr_ok   = (~aw_q[7] && 32'(wr_ch) < NCH) || aw_q == R_STATUS || aw_q == R_BUSY;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_q      <= 8'h00;
      w_q       <= 32'h0000_0000;
      ws_q      <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_q      <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_q      <= wdata;
        ws_q     <= wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path, answered one cycle after the address is taken
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [1:0]  rc;

  always_comb begin
    rc      = araddr[6:5];
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (!araddr[7] && 32'(rc) < NCH) begin
      unique case (araddr[4:0])
        R_CTRL:  rd_word = 32'(ctrl_q[rc]);
        R_REQ:   rd_word = {24'h000000, sel_q[rc]};
        R_STA:   rd_word = {16'h0000, sta_q[rc]};
        R_STB:   rd_word = {16'h0000, stb_q[rc]};
        R_PAD:   rd_word = {16'h0000, pad_q[rc]};
        R_LEN:   rd_word = {16'h0000, len_q[rc]};
        R_CUR:   rd_word = {16'h0000, cur_q[rc]};
        R_PROG:  rd_word = {15'h0000, pp_q[rc], cnt_q[rc]};
        default: rd_ok   = 1'b0;
      endcase
    end else if (araddr == R_STATUS) begin
      rd_word[NCH-1:0]               = full_st_q;
      rd_word[ST_HALF +: NCH]        = half_st_q;
    end else if (araddr == R_BUSY) begin
      rd_word = {20'h00000, state_q, ch_q, 4'(pend_q), 4'h0};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Engine decode for the channel in service
  logic [C_W-1:0] cc;
  logic [15:0]    mem_addr;
  logic [15:0]    src_addr;
  logic [15:0]    dst_addr;
  logic [1:0]     gch;
  logic           wr_done;
  logic [15:0]    nxt_cnt;
  logic           blk_end;
  logic           half_hit;

  assign gch      = pick(pend_q);
  assign cc       = ctrl_q[ch_q];
  assign wr_done  = (state_q == ST_WR) && dbus_ack;
  assign nxt_cnt  = cnt_q[ch_q] + 16'h0001;
  assign blk_end  = nxt_cnt >= eff_len(len_q[ch_q]);
  assign half_hit = cc[C_HALF] && len_q[ch_q] > 16'h0001 &&
                    nxt_cnt == (len_q[ch_q] >> 1);

  always_comb begin
    mem_addr = (amode_e'(ctrl_q[gch][C_AM +: 2]) == AM_PERIPH) ?
               periph_ind_addr : cur_q[gch];
    // Direction bit fixes the one way a channel ever moves data
    src_addr = ctrl_q[gch][C_DIR] ? mem_addr : pad_q[gch];
    dst_addr = ctrl_q[gch][C_DIR] ? pad_q[gch] : mem_addr;
  end

  assign dbus_req = (state_q != ST_IDLE);
  assign dbus_we  = (state_q == ST_WR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      ch_q       <= 2'd0;
      dbus_addr  <= 16'h0000;
      dbus_wdata <= 16'h0000;
      dbus_byte  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (|pend_q) begin
            ch_q      <= gch;
            dbus_addr <= src_addr;
            dbus_byte <= ctrl_q[gch][C_BYTE];
            state_q   <= ST_RD;
          end
        end
        ST_RD: begin
          if (dbus_ack) begin
            dbus_wdata <= cc[C_BYTE] ? {8'h00, dbus_rdata[7:0]} : dbus_rdata;
            dbus_addr  <= cc[C_DIR] ? pad_q[ch_q] :
                          ((amode_e'(cc[C_AM +: 2]) == AM_PERIPH) ?
                           periph_ind_addr : cur_q[ch_q]);
            state_q    <= ST_WR;
          end
        end
        ST_WR: begin
          if (dbus_ack) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture: peripheral edges when automatic, software force always
  logic [NCH-1:0] new_req;
  logic [NCH-1:0] grant;
  logic [SRC_W-1:0] ev_rise;

  assign ev_rise = irq_events & ~ev_prev_q;
  assign grant   = (state_q == ST_IDLE && |pend_q) ? NCH'(1) << gch : '0;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      new_req[i] = ctrl_q[i][C_EN] &&
                   ((ctrl_q[i][C_AUTO] && 32'(sel_q[i]) < SRC_W &&
                     ev_rise[sel_q[i]]) ||
                    (wr_fire && wr_ok && !aw_q[7] && 32'(wr_ch) == i &&
                     wr_reg == R_REQ && ws_q[3] && w_q[Q_FORCE]));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_q <= '0;
      pend_q    <= '0;
    end else begin
      ev_prev_q <= irq_events;
      // A fresh request in the grant cycle stays latched
      pend_q    <= (pend_q & ~grant) | new_req;
    end
  end

  // Channel state: software writes and block progress
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= '0;
        sel_q[i]  <= 8'h00;
        sta_q[i]  <= 16'h0000;
        stb_q[i]  <= 16'h0000;
        pad_q[i]  <= 16'h0000;
        len_q[i]  <= 16'h0000;
        cur_q[i]  <= 16'h0000;
        cnt_q[i]  <= 16'h0000;
      end
      pp_q      <= '0;
      full_st_q <= '0;
      half_st_q <= '0;
      half_irq  <= '0;
      full_irq  <= '0;
    end else begin
      half_irq <= '0;
      full_irq <= '0;
      if (wr_fire && aw_q == R_STATUS) begin
        full_st_q <= full_st_q & ~w_q[NCH-1:0];
        half_st_q <= half_st_q & ~w_q[ST_HALF +: NCH];
      end
      if (wr_done) begin
        if (amode_e'(cc[C_AM +: 2]) == AM_POSTINC) begin
          cur_q[ch_q] <= cur_q[ch_q] + (cc[C_BYTE] ? 16'h0001 : 16'h0002);
        end
        cnt_q[ch_q] <= nxt_cnt;
        if (half_hit) begin
          half_irq[ch_q]  <= 1'b1;
          half_st_q[ch_q] <= 1'b1;
        end
        if (blk_end) begin
          cnt_q[ch_q]     <= 16'h0000;
          full_irq[ch_q]  <= 1'b1;
          full_st_q[ch_q] <= 1'b1;
          unique case (mode_e'(cc[C_MODE +: 2]))
            MD_REPEAT: begin
              cur_q[ch_q] <= pp_q[ch_q] ? stb_q[ch_q] : sta_q[ch_q];
            end
            MD_PINGPONG: begin
              pp_q[ch_q]  <= ~pp_q[ch_q];
              cur_q[ch_q] <= pp_q[ch_q] ? sta_q[ch_q] : stb_q[ch_q];
            end
            default: begin
              ctrl_q[ch_q][C_EN] <= 1'b0;
            end
          endcase
        end
      end
      // Software write lands after progress so it wins on the same word
      if (wr_fire && !aw_q[7] && 32'(wr_ch) < NCH) begin
        unique case (wr_reg)
          R_CTRL: begin
            ctrl_q[wr_ch] <= C_W'(merge(32'(ctrl_q[wr_ch]), w_q, ws_q));
            if (!ctrl_q[wr_ch][C_EN] && ws_q[0] && w_q[C_EN]) begin
              cur_q[wr_ch] <= sta_q[wr_ch];
              cnt_q[wr_ch] <= 16'h0000;
              pp_q[wr_ch]  <= 1'b0;
            end
          end
          R_REQ: begin
            if (ws_q[0]) begin
              sel_q[wr_ch] <= w_q[7:0];
              pad_q[wr_ch] <= default_pad(w_q[7:0]);
            end
          end
          R_STA: sta_q[wr_ch] <= 16'(merge({16'h0000, sta_q[wr_ch]}, w_q, ws_q));
          R_STB: stb_q[wr_ch] <= 16'(merge({16'h0000, stb_q[wr_ch]}, w_q, ws_q));
          R_PAD: pad_q[wr_ch] <= 16'(merge({16'h0000, pad_q[wr_ch]}, w_q, ws_q));
          R_LEN: len_q[wr_ch] <= 16'(merge({16'h0000, len_q[wr_ch]}, w_q, ws_q));
          default: begin
          end
        endcase
      end
      // Hardware set wins over a simultaneous clear
      if (wr_done && blk_end) begin
        full_st_q[ch_q] <= 1'b1;
      end
      if (wr_done && half_hit) begin
        half_st_q[ch_q] <= 1'b1;
      end
    end
  end

endmodule

// ---- bench/dma_controller_chk.sv ----
// Concurrent checks on the transfer controller ports
`timescale 1ns/1ns
module dma_controller_chk
  import dma_pkg::*;
#(parameter int NCH = 4) (
  // Clock and reset
  input wire logic           clock,
  input wire logic           rst_n,
  // Register bus
  input wire logic           arvalid,
  input wire logic           arready,
  input wire logic           rvalid,
  input wire logic           rready,
  input wire logic [31:0]    rdata,
  input wire logic           bvalid,
  input wire logic           bready,
  input wire logic [1:0]     bresp,
  // Data bus and block events
  input wire logic           dbus_req,
  input wire logic           dbus_we,
  input wire logic           dbus_byte,
  input wire logic           dbus_ack,
  input wire logic [15:0]    dbus_addr,
  input wire logic [15:0]    dbus_wdata,
  input wire logic [NCH-1:0] half_irq,
  input wire logic [NCH-1:0] full_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not returned one cycle after address");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read address taken while data waits");
  a_phase_hold: assert property (dbus_req && !dbus_ack |=> dbus_req && $stable(dbus_addr))
    else $error("data bus phase changed before acknowledge");
  a_phase_order: assert property (dbus_req && !dbus_we && dbus_ack |=> dbus_req && dbus_we)
    else $error("read phase not followed by write phase");
  a_element_end: assert property (dbus_req && dbus_we && dbus_ack |=> !dbus_req [*1])
    else $error("no idle cycle after an element");
  a_byte_upper: assert property (dbus_req && dbus_we && dbus_byte |-> dbus_wdata[15:8] == 8'h00)
    else $error("byte element carries upper data");
  a_full_cause: assert property (full_irq != '0 |-> $past(dbus_req && dbus_we && dbus_ack))
    else $error("block event without a finished element");
  a_half_cause: assert property (half_irq != '0 |-> $past(dbus_req && dbus_we && dbus_ack))
    else $error("half event without a finished element");
  a_event_pulse: assert property ((full_irq | half_irq) != '0 |=> (full_irq | half_irq) == '0)
    else $error("block event longer than one cycle");
  a_one_channel: assert property ($onehot0(full_irq))
    else $error("two channels finished together");
  c_half: cover property (half_irq != '0);
  c_full: cover property (full_irq != '0);
  c_byte: cover property (dbus_req && dbus_we && dbus_byte);
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule

bind dma_controller dma_controller_chk #(.NCH(NCH)) dma_controller_chk_i (
  .clock, .rst_n, .arvalid, .arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp,
  .dbus_req, .dbus_we, .dbus_byte, .dbus_ack, .dbus_addr, .dbus_wdata, .half_irq, .full_irq
);

// ---- bench/dbus_model.sv ----
// Data-bus slave standing in for memory and peripheral ports
`timescale 1ns/1ns
module dbus_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Data bus from the controller
  input  wire logic        dbus_req,
  input  wire logic        dbus_we,
  input  wire logic [15:0] dbus_addr,
  input  wire logic [15:0] dbus_wdata,
  output logic             dbus_ack,
  output logic [15:0]      dbus_rdata,
  // Write log for the bench
  output logic [15:0]      last_addr,
  output logic [15:0]      last_data,
  output logic [7:0]       wr_cnt
);
  logic [1:0] wait_q;
  logic       slow_q;
  // Prompt and slow phases alternate so both latencies are exercised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dbus_ack <= 1'b0;
      dbus_rdata <= 16'h0000;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
    end else if (dbus_req && !dbus_ack && wait_q == (slow_q ? 2'h3 : 2'h0)) begin
      dbus_ack <= 1'b1;
      dbus_rdata <= dbus_addr ^ 16'h5A5A;
      wait_q <= 2'h0;
      slow_q <= !slow_q;
    end else begin
      dbus_ack <= 1'b0;
      // Data outside an answer toggles each cycle so a sample taken one cycle late never matches
      dbus_rdata <= ~dbus_rdata;
      wait_q <= (dbus_req && !dbus_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
      wr_cnt <= 8'h00;
    end else if (dbus_req && dbus_we && dbus_ack) begin
      last_addr <= dbus_addr;
      last_data <= dbus_wdata;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule

// ---- bench/dma_controller_tb.sv ----
// Register-driven scenarios for the transfer controller
`timescale 1ns/1ns
module dma_controller_tb
  import dma_pkg::*;
;
  localparam logic [31:0] EN = 32'h1 << C_EN;
  localparam logic [31:0] BYTE = 32'h1 << C_BYTE;
  localparam logic [31:0] DIR = 32'h1 << C_DIR;
  localparam logic [31:0] HALF = 32'h1 << C_HALF;
  localparam logic [31:0] FIX = 32'h1 << C_AM;
  localparam logic [31:0] PIND = 32'h2 << C_AM;
  localparam logic [31:0] REP = 32'h1 << C_MODE;
  localparam logic [31:0] PP = 32'h2 << C_MODE;
  localparam logic [31:0] AUTO = 32'h1 << C_AUTO;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]   wdata = 32'h0, rdata, rd;
  logic [3:0]    wstrb = 4'hF, half_irq, full_irq;
  logic [255:0]  irq_events = '0;
  logic [15:0]   periph_ind_addr = 16'h0, dbus_addr, dbus_wdata, dbus_rdata, last_addr, last_data;
  logic          awready, wready, bvalid, arready, rvalid, dbus_req, dbus_we, dbus_byte, dbus_ack;
  logic [1:0]    bresp, rresp, rs;
  logic [7:0]    wr_cnt;
  logic [7:0]    codes [6] = '{SRC_EXT_INT_ZERO, SRC_CAPTURE1, SRC_COMPARE1, SRC_CONV_DONE,
                               SRC_CAN_RX, SRC_CAN_TX};
  logic [15:0]   ports [6] = '{PAD_NONE, CAPTURE_ONE_BUFFER, COMPARE_ONE_PRIMARY,
                               CONVERTER_RESULT_ZERO, CAN_RECEIVE_PORT, CAN_TRANSMIT_PORT};
  logic [15:0]   pp_addr [3] = '{16'h3000, 16'h3100, 16'h3000};
  int            error_cnt = 0, comparisons = 0, seen = 0, half_n = 0, full_n = 0;

  dma_controller dma_controller_i (
    .clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .irq_events, .periph_ind_addr, .dbus_req, .dbus_we, .dbus_byte, .dbus_addr, .dbus_wdata,
    .dbus_ack, .dbus_rdata, .half_irq, .full_irq
  );
  dbus_model dbus_model_i (
    .clock, .rst_n, .dbus_req, .dbus_we, .dbus_addr, .dbus_wdata, .dbus_ack, .dbus_rdata,
    .last_addr, .last_data, .wr_cnt
  );

  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    half_n += $countones(half_irq);
    full_n += $countones(full_irq);
  end

  function automatic logic [7:0] ra(int ch, logic [4:0] r);
    return {ch[2:0], r};
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data are offered together and each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    check(n, e, rd);
  endtask
  task automatic setup(input int ch, input logic [31:0] c, input logic [15:0] sa,
                       input logic [15:0] sb, input logic [7:0] code);
    axi_write(ra(ch, R_CTRL), 32'h0, 4'hF);
    axi_write(ra(ch, R_STA), 32'(sa), 4'hF);
    axi_write(ra(ch, R_STB), 32'(sb), 4'hF);
    axi_write(ra(ch, R_LEN), 32'h1, 4'hF);
    axi_write(ra(ch, R_REQ), 32'(code), 4'hF);
    axi_write(ra(ch, R_CTRL), c, 4'hF);
  endtask
  // Only the top strobe, so the select and peripheral address stay as set
  task automatic force_el(input int ch);
    axi_write(ra(ch, R_REQ), 32'h8000_0000, 4'h8);
  endtask
  task automatic exp_wr(input string n, input logic [15:0] a, input logic [15:0] d);
    seen++;
    for (int i = 0; i < 300 && wr_cnt !== 8'(seen); i++) @(posedge clock);
    check(n, {a, d}, {last_addr, last_data});
  endtask
  task automatic ev(input logic [255:0] m);
    @(posedge clock);
    irq_events <= m;
    @(posedge clock);
    irq_events <= '0;
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk("ctrl_reset", ra(0, R_CTRL), 32'h0);
    rd_chk("status_reset", R_STATUS, 32'h0);
    axi_read(8'h90);
    check("unmapped_rresp", 32'(RESP_SLVERR), 32'(rs));
    check("unmapped_rdata", 32'h0, rd);
    axi_write(8'h90, 32'h1, 4'hF);
    check("unmapped_bresp", 32'(RESP_SLVERR), 32'(rs));
    foreach (codes[i]) begin
      axi_write(ra(0, R_REQ), 32'(codes[i]), 4'hF);
      rd_chk("pad_default", ra(0, R_PAD), 32'(ports[i]));
    end
    // Two-element word block with the half event enabled
    setup(0, EN | HALF, 16'h1000, 16'h0, SRC_CAPTURE1);
    axi_write(ra(0, R_LEN), 32'h2, 4'hF);
    force_el(0);
    exp_wr("elem0", 16'h1000, CAPTURE_ONE_BUFFER ^ 16'h5A5A);
    force_el(0);
    exp_wr("elem1", 16'h1002, CAPTURE_ONE_BUFFER ^ 16'h5A5A);
    rd_chk("status_flags", R_STATUS, 32'h0000_0101);
    check("half_events", 32'h1, 32'(half_n));
    check("full_events", 32'h1, 32'(full_n));
    rd_chk("oneshot_stop", ra(0, R_CTRL), HALF);
    axi_write(R_STATUS, 32'h0000_0101, 4'hF);
    rd_chk("status_clear", R_STATUS, 32'h0);
    // Separate channel for the writing direction, bytes to the secondary compare
    setup(2, EN | BYTE | DIR | FIX | REP, 16'h2001, 16'h0, SRC_COMPARE1);
    axi_write(ra(2, R_PAD), 32'(COMPARE_ONE_SECONDARY), 4'hF);
    // Two elements per block, so a moving source address would change the data
    axi_write(ra(2, R_LEN), 32'h2, 4'hF);
    repeat (2) begin
      force_el(2);
      exp_wr("byte_fixed", COMPARE_ONE_SECONDARY, 16'h005B);
    end
    rd_chk("repeat_stays", ra(2, R_CTRL), EN | BYTE | DIR | FIX | REP);
    setup(1, EN | PP, 16'h3000, 16'h3100, SRC_CAN_RX);
    foreach (pp_addr[i]) begin
      force_el(1);
      exp_wr("pingpong", pp_addr[i], CAN_RECEIVE_PORT ^ 16'h5A5A);
    end
    periph_ind_addr <= 16'h4444;
    setup(3, EN | PIND | AUTO, 16'h0, 16'h0, SRC_CONV_DONE);
    ev(256'h1 << SRC_CONV_DONE);
    exp_wr("indirect", 16'h4444, CONVERTER_RESULT_ZERO ^ 16'h5A5A);
    // Both channels raised in one cycle; the loser must stay pending
    setup(0, EN | AUTO, 16'h5000, 16'h0, SRC_EXT_INT_ZERO);
    setup(1, EN | DIR | AUTO, 16'h6000, 16'h0, SRC_CAN_TX);
    ev((256'h1 << SRC_EXT_INT_ZERO) | (256'h1 << SRC_CAN_TX));
    exp_wr("first_grant", 16'h5000, PAD_NONE ^ 16'h5A5A);
    exp_wr("second_grant", CAN_TRANSMIT_PORT, 16'h6000 ^ 16'h5A5A);
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    results();
  end
endmodule
